// File: hw/asf_defs.svh
// Constants of the acceleration sample frame buffer: register indices, field positions, reset values, timing.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH
`define ASF_FRAMES 32
`define ASF_PTR_W 5
`define ASF_CNT_W 6
`define ASF_DEPTH_FIFO 6'h20
`define ASF_DEPTH_STREAM 6'h1f
`define ASF_DEPTH_BYPASS 6'h01
`define ASF_IDX_INT_STATUS 6'h0a
`define ASF_IDX_FILL 6'h0e
`define ASF_IDX_INT_EN 6'h17
`define ASF_IDX_INT_MAP 6'h1a
`define ASF_IDX_WM 6'h30
`define ASF_IDX_MODE 6'h3e
`define ASF_IDX_DATA 6'h3f
`define ASF_EN_WM_BIT 5
`define ASF_EN_FULL_BIT 6
`define ASF_MAP_FULL1_BIT 1
`define ASF_MAP_WM1_BIT 2
`define ASF_MAP_FULL2_BIT 5
`define ASF_MAP_WM2_BIT 6
`define ASF_RESP_OKAY 2'h0
`define ASF_RESP_SLVERR 2'h2
`define ASF_RST_BYTE 8'h00
`define ASF_RST_WM 6'h00
`define ASF_GAP_NS 1500
`define ASF_CLK_NS 4
`define ASF_GAP_CYC ((`ASF_GAP_NS + `ASF_CLK_NS - 1) / `ASF_CLK_NS)
`define ASF_GAP_W 9
`define ASF_FRAME_BYTES 3'h6
`define ASF_AXIS_BYTES 3'h2
`endif

// File: hw/asf_pkg.sv
// Types shared by the acceleration sample frame buffer.
// Assumes the constants header sits beside it.
`include "asf_defs.svh"
package asf_pkg;
  // Operating mode codes as held in the mode field.
  typedef enum logic [1:0] {
    ASF_BYPASS = 2'b00,
    ASF_FIFO = 2'b01,
    ASF_STREAM = 2'b10
  } asf_mode_type;

  // One frame: three axes from one sampling instant.
  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } asf_sample_type;

  // Whole state of the block, registered in one process.
  typedef struct packed {
    asf_sample_type [`ASF_FRAMES-1:0] mem;
    logic [`ASF_PTR_W-1:0] wr_ptr;
    logic [`ASF_PTR_W-1:0] rd_ptr;
    logic [`ASF_CNT_W-1:0] cnt;
    logic [2:0] byte_idx;
    logic [`ASF_GAP_W-1:0] gap;
    logic ovr;
    logic wm_st;
    logic full_st;
    asf_mode_type mode;
    logic [1:0] sel;
    logic [`ASF_CNT_W-1:0] wm;
    logic [7:0] int_en;
    logic [7:0] int_map;
    logic pin1;
    logic pin2;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } asf_state_type;
endpackage

// File: hw/asf_fifo.sv
// Acceleration sample frame buffer with an AXI4-Lite register slave.
// Assumes samples arrive as a one-cycle strobe on clk from the filter path.
//
// How it works
// R1 - Holds 32 frames of three 16-bit axes.
// R2 - Fifo mode stops at 32, ignores extra.
// R3 - Stream mode: depth 31, drops oldest.
// R4 - Bypass: stream with depth one.
// R5 - Mode 00 bypass, 01 fifo, 10 stream.
// R6 - Mode write empties buffer, clears events.
// R7 - Mode field reads the mode in effect.
// R8 - Stores the same values as output registers.
// R9 - Burst reads stay trapped on data port; not done here, each data port access is decoded alone.
// R10 - Axis select: all, x, y, z.
// R11 - Frame depth independent of axis select.
// R12 - Partial frame read drops frame remainder.
// R13 - Host waits 1.5 us after partial frame.
// R14 - Reading empty buffer returns zero.
// R15 - Host finishes overread within sample period.
// R16 - Frame count shows frames held.
// R17 - Overrun set on arrival while full.
// R18 - Mode or watermark write clears count, overrun.
// R19 - Overrun survives draining to zero.
// R20 - Watermark event at programmed level, enabled, mapped.
// R21 - Full event after 32, 31, 1 samples.
// R22 - Full event gated by enable and map.
// R23 - Axes x,y,z order, low byte first.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module asf_fifo
  import asf_pkg::*;
(
  input wire logic clk, // System clock, 250 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic sample_valid, // One-cycle strobe of a new sample.
  input wire asf_sample_type sample, // Filtered acceleration, all axes.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic interrupt_pin_one, // First interrupt pin, active high.
  output logic interrupt_pin_two // Second interrupt pin, active high.
);

  // Register state and its next value.
  asf_state_type s_q;
  asf_state_type s_d;

  // Handshake terms, decoded addresses and helpers.
  logic wr_go;
  logic rd_go;
  logic cfg_clr;
  logic [5:0] widx;
  logic [5:0] ridx;
  logic wmap;
  logic rmap;
  logic [`ASF_CNT_W-1:0] dep;
  logic [7:0] rbyte;
  logic ev_wm;
  logic ev_full;

  // Frame depth of each mode; the axis select plays no part in it. [R11]
  function automatic logic [`ASF_CNT_W-1:0] depth_of(input asf_mode_type m);
    logic [`ASF_CNT_W-1:0] d;
    d = `ASF_DEPTH_BYPASS; // Bypass keeps only the latest frame. [R4]
    case (m)
      ASF_FIFO: d = `ASF_DEPTH_FIFO; // [R1] [R2]
      ASF_STREAM: d = `ASF_DEPTH_STREAM; // [R3]
      default: d = `ASF_DEPTH_BYPASS;
    endcase
    return d;
  endfunction

  // Bytes per frame as read from the data port.
  function automatic logic [2:0] frame_len(input logic [1:0] sel);
    return (sel == 2'h0) ? `ASF_FRAME_BYTES : `ASF_AXIS_BYTES; // [R10]
  endfunction

  // One byte of a frame: axes in x, y, z order, low byte first. [R23]
  function automatic logic [7:0] frame_byte(input asf_sample_type f, input logic [1:0] sel,
                                            input logic [2:0] idx);
    logic [15:0] w;
    w = f.x;
    if (sel == 2'h1) begin
      w = f.x;
    end else if (sel == 2'h2) begin
      w = f.y;
    end else if (sel == 2'h3) begin
      w = f.z;
    end else if (idx[2:1] == 2'h1) begin
      w = f.y;
    end else if (idx[2:1] == 2'h2) begin
      w = f.z;
    end
    return idx[0] ? w[15:8] : w[7:0];
  endfunction

  // Word address to register index; anything above the byte space is unmapped.
  function automatic logic [5:0] reg_index(input logic [31:0] a);
    return a[7:2];
  endfunction

  // Whether an address lands on a register of this block.
  function automatic logic is_mapped(input logic [31:0] a);
    logic [5:0] i;
    i = a[7:2];
    if (a[31:8] != 24'h00_0000) begin
      return 1'b0;
    end else if (i == `ASF_IDX_INT_STATUS || i == `ASF_IDX_FILL || i == `ASF_IDX_INT_EN) begin
      return 1'b1;
    end else if (i == `ASF_IDX_INT_MAP || i == `ASF_IDX_WM || i == `ASF_IDX_MODE) begin
      return 1'b1;
    end else if (i == `ASF_IDX_DATA) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  // Bus handshakes: a write waits until address and data are both offered,
  // which keeps one decode path at the cost of not taking them apart.
  always_comb begin
    wr_go = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
    rd_go = s_axi_arvalid & ~s_q.rvalid;
    s_axi_awready = wr_go;
    s_axi_wready = wr_go;
    s_axi_arready = ~s_q.rvalid;
    widx = reg_index(s_axi_awaddr);
    ridx = reg_index(s_axi_araddr);
    wmap = is_mapped(s_axi_awaddr);
    rmap = is_mapped(s_axi_araddr);
    dep = depth_of(s_q.mode);
    // Writes to the mode or watermark register restart the buffer. [R6] [R18]
    cfg_clr = wr_go & wmap & s_axi_wstrb[0] & (widx == `ASF_IDX_MODE || widx == `ASF_IDX_WM);
  end

  // Byte the data port would give now; an empty buffer gives zero. [R14]
  always_comb begin
    rbyte = `ASF_RST_BYTE;
    if (s_q.cnt != 6'h00) begin
      rbyte = frame_byte(s_q.mem[s_q.rd_ptr], s_q.sel, s_q.byte_idx);
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;
    ev_wm = 1'b0;
    ev_full = 1'b0;

    // Responses stand until the master takes them.
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // A frame left half read is dropped once the bus has stayed off the data
    // port for the settling gap; a quicker return just continues the frame. [R12] [R13]
    if (s_q.byte_idx != 3'h0) begin
      if (s_q.gap == `ASF_GAP_W'(`ASF_GAP_CYC)) begin
        s_d.byte_idx = 3'h0;
        s_d.gap = '0;
        s_d.rd_ptr = s_q.rd_ptr + 5'h01;
        s_d.cnt = s_q.cnt - 6'h01;
      end else begin
        s_d.gap = s_q.gap + `ASF_GAP_W'(1);
      end
    end

    // Register reads; the serial address counter that traps bursts lives in
    // the host interface, so here every data port access is decoded alone. [R9]
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = rmap ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      if (!rmap) begin
        s_d.rdata = 32'h0000_0000;
      end else if (ridx == `ASF_IDX_DATA) begin
        s_d.rdata = {24'h00_0000, rbyte};
        s_d.gap = '0;
        if (s_q.cnt != 6'h00) begin
          if (s_q.byte_idx + 3'h1 == frame_len(s_q.sel)) begin
            s_d.byte_idx = 3'h0; // Whole frame read: release it.
            s_d.rd_ptr = s_q.rd_ptr + 5'h01;
            s_d.cnt = s_q.cnt - 6'h01;
          end else begin
            s_d.byte_idx = s_q.byte_idx + 3'h1;
            s_d.rd_ptr = s_q.rd_ptr;
            s_d.cnt = s_q.cnt;
          end
        end
      end else if (ridx == `ASF_IDX_FILL) begin
        s_d.rdata = {24'h00_0000, s_q.ovr, 1'b0, s_q.cnt}; // [R16]
      end else if (ridx == `ASF_IDX_INT_STATUS) begin
        s_d.rdata = {30'h0000_0000, s_q.full_st, s_q.wm_st}; // [R22]
      end else if (ridx == `ASF_IDX_INT_EN) begin
        s_d.rdata = {24'h00_0000, s_q.int_en};
      end else if (ridx == `ASF_IDX_INT_MAP) begin
        s_d.rdata = {24'h00_0000, s_q.int_map};
      end else if (ridx == `ASF_IDX_WM) begin
        s_d.rdata = {26'h000_0000, s_q.wm};
      end else if (ridx == `ASF_IDX_MODE) begin
        s_d.rdata = {24'h00_0000, s_q.mode, 4'h0, s_q.sel}; // [R7]
      end
    end

    // Register writes; read-only and unmapped targets ignore the data.
    if (wr_go) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = wmap ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
      if (wmap && s_axi_wstrb[0]) begin
        if (widx == `ASF_IDX_MODE) begin
          if (s_axi_wdata[7:6] != 2'h3) begin
            s_d.mode = asf_mode_type'(s_axi_wdata[7:6]); // [R5] Code 11 is kept out.
          end
          s_d.sel = s_axi_wdata[1:0]; // [R10]
        end else if (widx == `ASF_IDX_WM) begin
          s_d.wm = s_axi_wdata[5:0];
        end else if (widx == `ASF_IDX_INT_EN) begin
          s_d.int_en = s_axi_wdata[7:0];
        end else if (widx == `ASF_IDX_INT_MAP) begin
          s_d.int_map = s_axi_wdata[7:0];
        end
      end
    end

    // Configuration clear empties the buffer, count, overrun and events.
    // Only this clears the overrun flag, never a drain. [R6] [R18] [R19]
    if (cfg_clr) begin
      s_d.wr_ptr = '0;
      s_d.rd_ptr = '0;
      s_d.cnt = '0;
      s_d.byte_idx = 3'h0;
      s_d.gap = '0;
      s_d.ovr = 1'b0;
      s_d.wm_st = 1'b0;
      s_d.full_st = 1'b0;
    end

    // Sample arrival works on the already cleared state, so an event in the
    // clearing cycle is kept. The frame is the same data as the output
    // registers carry, all axes stored whatever the select. [R8]
    if (sample_valid) begin
      if (s_d.cnt < depth_of(s_d.mode)) begin
        s_d.mem[s_d.wr_ptr] = sample; // [R1]
        s_d.wr_ptr = s_d.wr_ptr + 5'h01;
        s_d.cnt = s_d.cnt + 6'h01;
        ev_wm = (s_d.wm != 6'h00) && (s_d.cnt == s_d.wm); // [R20]
        ev_full = (s_d.cnt == depth_of(s_d.mode)); // [R21]
      end else if (s_d.mode == ASF_FIFO) begin
        s_d.ovr = 1'b1; // Full fifo ignores the sample. [R2] [R17]
      end else begin
        s_d.mem[s_d.wr_ptr] = sample; // Oldest frame gives way. [R3] [R4]
        s_d.wr_ptr = s_d.wr_ptr + 5'h01;
        s_d.rd_ptr = s_d.rd_ptr + 5'h01;
        s_d.byte_idx = 3'h0;
        s_d.ovr = 1'b1; // [R17]
        ev_wm = (s_d.wm != 6'h00) && (s_d.cnt == s_d.wm); // Level held: still reached. [R20]
      end
      if (ev_wm) begin
        s_d.wm_st = 1'b1;
      end
      if (ev_full) begin
        s_d.full_st = 1'b1;
      end
    end

    // Pin routing: each event needs its enable and that pin's map bit. [R20] [R22]
    s_d.pin1 = (s_d.wm_st & s_d.int_en[`ASF_EN_WM_BIT] & s_d.int_map[`ASF_MAP_WM1_BIT])
             | (s_d.full_st & s_d.int_en[`ASF_EN_FULL_BIT] & s_d.int_map[`ASF_MAP_FULL1_BIT]);
    s_d.pin2 = (s_d.wm_st & s_d.int_en[`ASF_EN_WM_BIT] & s_d.int_map[`ASF_MAP_WM2_BIT])
             | (s_d.full_st & s_d.int_en[`ASF_EN_FULL_BIT] & s_d.int_map[`ASF_MAP_FULL2_BIT]);
  end

  // State register; reset clears the whole state, frame storage included,
  // then loads the reset values of mode, watermark, enables, map and responses.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= ASF_BYPASS;
      s_q.wm <= `ASF_RST_WM;
      s_q.int_en <= `ASF_RST_BYTE;
      s_q.int_map <= `ASF_RST_BYTE;
      s_q.bresp <= `ASF_RESP_OKAY;
      s_q.rresp <= `ASF_RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  always_comb begin
    s_axi_bvalid = s_q.bvalid;
    s_axi_bresp = s_q.bresp;
    s_axi_rvalid = s_q.rvalid;
    s_axi_rresp = s_q.rresp;
    s_axi_rdata = s_q.rdata;
    interrupt_pin_one = s_q.pin1;
    interrupt_pin_two = s_q.pin2;
  end

endmodule // asf_fifo

// File: dv/asf_fifo_chk.sv
// Checker of the frame buffer's register bus handshakes.
// Assumes it is bound to asf_fifo and sees only that module's ports.
`timescale 1ns/1ps
`include "asf_defs.svh"
module asf_fifo_chk (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset, active high.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp // Read response.
);
  // One domain, so clock and reset are given once for all properties.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_write_answer_next: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response late");
  chk_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_rvalid_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  chk_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_awready_rule: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready wrong");
  chk_arready_rule: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  // An address above the register space must be refused with zero data.
  chk_far_addr_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:8] != 24'h0
    |=> s_axi_rresp == `ASF_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("far address not refused");
endmodule // asf_fifo_chk
bind asf_fifo asf_fifo_chk chk_i (.clk, .rst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp);

// File: dv/asf_src.sv
// Model of the filter path that hands frames to the buffer.
// Assumes the buffer's clock; one strobe for each request on go.
`timescale 1ns/1ps
module asf_src
  import asf_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst, // Reset, active high.
  input wire logic go, // Request for one strobe.
  output logic sample_valid, // One-cycle strobe.
  output asf_sample_type sample // Three axes of one instant.
);
  int seed = 32'h57f9; // Fixed seed keeps runs repeatable.
  // Between strobes the data is inverted each cycle, so a late capture cannot match.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_valid <= 1'b0;
      sample <= '0;
    end else if (go) begin
      sample_valid <= 1'b1;
      sample <= 48'({$random(seed), $random(seed)}); // All axes from one instant.
    end else begin
      sample_valid <= 1'b0;
      sample <= ~sample;
    end
  end
endmodule // asf_src

// File: dv/testbench.sv
// Self-checking bench of the frame buffer: samples from asf_src, registers over AXI4-Lite.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`include "asf_defs.svh"
module testbench
  import asf_pkg::*;
;
  logic clk, rst, go, sv, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic p1, p2, m_ovr;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, r, m_mode, m_sel;
  asf_sample_type smp;
  asf_sample_type mq[$]; // Expected frames, oldest first.
  int fails, check_count, bi;
  logic [1:0] modes [4] = '{2'b01, 2'b10, 2'b00, 2'b01}; // Fifo, stream, bypass codes.
  asf_fifo dut (.clk(clk), .rst(rst), .sample_valid(sv), .sample(smp), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .interrupt_pin_one(p1), .interrupt_pin_two(p2));
  asf_src src (.clk(clk), .rst(rst), .go(go), .sample_valid(sv), .sample(smp));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic int depth(logic [1:0] m);
    return (m == 2'b01) ? 32 : (m == 2'b10) ? 31 : 1;
  endfunction
  // Byte k of a frame as the data port hands it out: x, y, z, low byte first.
  function automatic logic [7:0] exp_byte(asf_sample_type f, logic [1:0] s, int k);
    logic [15:0] w;
    w = (s == 2'b00) ? f[k / 2 * 16 +: 16] : f[(s - 1) * 16 +: 16];
    return (k % 2) ? w[15:8] : w[7:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Model of storage: what the buffer should hold after each strobe.
  always @(negedge clk) begin
    if (sv === 1'b1) begin
      if (mq.size() < depth(m_mode)) begin
        mq.push_back(smp); // Same values as the output registers.
      end else begin
        m_ovr = 1'b1;
        if (m_mode != 2'b01) begin
          void'(mq.pop_front());
          mq.push_back(smp);
        end
      end
    end
  end
  // Ready and valid are looked at half a cycle early, so no race with the edge that moves them.
  task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge clk);
    bready <= 1'b0;
    if (idx == 8'h3e || idx == 8'h30) begin
      mq.delete();
      m_ovr = 1'b0;
      bi = 0;
      if (idx == 8'h3e) begin
        m_sel = v[1:0]; // The select is taken even when the mode code is refused.
        if (v[7:6] != 2'b11) begin
          m_mode = v[7:6];
        end
      end
    end
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    data = rdata;
    resp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic push(input int n);
    repeat (n) begin
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  // Reads n bytes from the data port; past the stored frames zero is expected.
  task automatic drain(input int n);
    logic [7:0] e;
    repeat (n) begin
      rd(8'h3f, d, r);
      e = 8'h00;
      if (mq.size() > 0) begin
        e = exp_byte(mq[0], m_sel, bi);
        bi++;
        if (bi == ((m_sel == 2'b00) ? 6 : 2)) begin
          void'(mq.pop_front());
          bi = 0;
        end
      end
      check(d, {24'h0, e});
    end
  endtask
  task automatic give_verdict();
    $display("fails %0d check_count %0d", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog: the run needs under 2000 cycles, this allows 25000.
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  initial begin
    {go, awvalid, wvalid, bready, arvalid, rready, m_ovr} = '0;
    {awaddr, wdata, araddr, m_mode, m_sel, fails, check_count, bi} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (modes[i]) begin
      rd(8'h0e + 8'(i % 2) * 8'h22, d, r); // Fill and watermark start at zero.
      check(d, 32'h0);
    end
    rd(8'h40, d, r);
    check({d[29:0], r}, {30'h0, `ASF_RESP_SLVERR}); // Far address refused.
    wr(8'h20, 8'h5a, r);
    check(32'(r), 32'(`ASF_RESP_SLVERR)); // Unmapped write refused.
    // Overfill every mode and axis choice, then drain past the end.
    foreach (modes[i]) begin
      wr(8'h3e, {modes[i], 4'h0, 2'(i)}, r);
      push(35);
      rd(8'h0e, d, r);
      check(d, {24'h0, m_ovr, 1'b0, 6'(mq.size())});
      rd(8'h0a, d, r);
      check(d & 32'h3, 32'h2);
      rd(8'h3e, d, r);
      check({d[7:6], d[1:0]}, {m_mode, m_sel});
      drain(mq.size() * ((m_sel == 2'b00) ? 6 : 2) + 2); // Each overread within one sample period.
      rd(8'h0e, d, r);
      check(d, 32'h80);
    end
    // Watermark on pin one, then full on pin two in bypass.
    wr(8'h3e, 8'h40, r);
    wr(8'h30, 8'h03, r);
    wr(8'h17, 8'h60, r);
    wr(8'h1a, 8'h24, r);
    push(2);
    check(32'(p1), 32'h0);
    push(1);
    check({p2, p1}, 32'h1);
    wr(8'h30, 8'h03, r);
    rd(8'h0e, d, r);
    check(d, 32'h0);
    rd(8'h0a, d, r);
    check(d & 32'h3, 32'h0);
    wr(8'h3e, 8'h00, r);
    push(1);
    check({p2, p1}, 32'h2);
    // A half-read frame is dropped after a quiet gap on the data port.
    wr(8'h3e, 8'h40, r);
    push(2);
    drain(2);
    repeat (400) @(posedge clk); // Gap beyond 1.5 us before the next access.
    void'(mq.pop_front());
    bi = 0;
    drain(8);
    rd(8'h0e, d, r);
    check(d, 32'h0);
    // The unused mode code leaves the mode in effect but still sets the select.
    wr(8'h3e, 8'hc2, r);
    rd(8'h3e, d, r);
    check({d[7:6], d[1:0]}, {m_mode, m_sel});
    give_verdict();
  end
endmodule // testbench
